/* File: iuv_sequencer.sv */
// ====================================================================
// Input undervoltage fault response, turn-on delay and power-good
// Assumes command access arrives on its own link clock, measurements
// come from a slowly updating converter in 8.8 volt format.
`timescale 1ns/1ps
`include "iuv_defines.svh"

module iuv_sequencer
	import iuv_pkg::*;
#(
	parameter int MS_CYCLES = `IUV_MS_CYCLES
)(
	input  wire  logic         SYS_CLK,
	input  wire  logic         RSTN,
	input  wire  logic         LINK_CLK,
	input  wire  logic         LINK_WR_STB,
	input  wire  logic         LINK_RD_STB,
	input  wire  logic [7:0]   LINK_CODE,
	input  wire  logic [15:0]  LINK_WDATA,
	output logic [15:0]        LINK_RDATA,
	output logic               LINK_DONE,
	output logic               LINK_REJECT,
	output logic               LINK_BUSY,
	input  wire  logic         ENABLE_PIN,
	input  wire  logic         OP_ON,
	input  wire  logic         OTHER_FAULT,
	input  wire  logic [15:0]  VIN_MEAS,
	input  wire  logic [15:0]  VOUT_MEAS,
	input  wire  logic [15:0]  VIN_UV_WARN,
	input  wire  logic [15:0]  VOUT_UV_FAULT,
	output logic               OUTPUT_EN,
	output logic               POWER_GOOD,
	output logic               ALERT_LINE_N,
	output logic               STATUS_NOTA,
	output logic               STATUS_INPUT_SUM,
	output logic               UV_FAULT_FLAG
);

	// ====================================================================
	// Link domain: capture a request and hold it while busy
	logic         lk_req_tgl_r;
	logic         lk_busy_r;
	logic         lk_wr_r;
	logic [7:0]   lk_code_r;
	logic [15:0]  lk_data_r;
	logic [15:0]  lk_rdata_r;
	logic         lk_done_r;
	logic         lk_rej_r;
	logic [1:0]   lk_ack_sync_r;
	logic         lk_ack_seen_r;
	logic         sys_ack_tgl_r;
	logic [15:0]  sys_rdata_r;
	logic         sys_rej_r;

	wire lk_new_req = (LINK_WR_STB || LINK_RD_STB) && !lk_busy_r;
	wire lk_ack_ev  = lk_ack_sync_r[1] != lk_ack_seen_r;

	// Strobes while busy are dropped; the host watches LINK_BUSY
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			lk_req_tgl_r <= 1'b0;
			lk_busy_r    <= 1'b0;
			lk_wr_r      <= 1'b0;
			lk_code_r    <= 8'h00;
			lk_data_r    <= 16'h0000;
		end else if (lk_new_req) begin
			lk_req_tgl_r <= ~lk_req_tgl_r;
			lk_busy_r    <= 1'b1;
			lk_wr_r      <= LINK_WR_STB;
			lk_code_r    <= LINK_CODE;
			lk_data_r    <= LINK_WDATA;
		end else if (lk_ack_ev) begin
			lk_busy_r    <= 1'b0;
		end
	end

	// Acknowledge returns as a toggle; answer words are stable by then
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			lk_ack_sync_r <= 2'h0;
			lk_ack_seen_r <= 1'b0;
			lk_done_r     <= 1'b0;
			lk_rej_r      <= 1'b0;
			lk_rdata_r    <= 16'h0000;
		end else begin
			lk_ack_sync_r <= {lk_ack_sync_r[0], sys_ack_tgl_r};
			lk_ack_seen_r <= lk_ack_sync_r[1];
			lk_done_r     <= lk_ack_ev;
			if (lk_ack_ev) begin
				lk_rej_r   <= sys_rej_r;
				lk_rdata_r <= sys_rdata_r;
			end
		end
	end

	assign LINK_RDATA  = lk_rdata_r;
	assign LINK_DONE   = lk_done_r;
	assign LINK_REJECT = lk_rej_r;
	assign LINK_BUSY   = lk_busy_r;

	// ====================================================================
	// System domain: synchronisers for the request toggle and the pins
	logic [1:0]   req_sync_r;
	logic         req_seen_r;
	logic [1:0]   en_sync_r;
	logic [1:0]   oth_sync_r;
	logic [15:0]  vin_s1_r;
	logic [15:0]  vin_r;
	logic [15:0]  vout_s1_r;
	logic [15:0]  vout_r;

	// Measurements change slowly, so a two-stage copy of the word is safe;
	// the input copy resets high so that leaving reset is not a falling crossing
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			req_sync_r <= 2'h0;
			req_seen_r <= 1'b0;
			en_sync_r  <= 2'h0;
			oth_sync_r <= 2'h0;
			vin_s1_r   <= 16'hffff;
			vin_r      <= 16'hffff;
			vout_s1_r  <= 16'h0000;
			vout_r     <= 16'h0000;
		end else begin
			req_sync_r <= {req_sync_r[0], lk_req_tgl_r};
			req_seen_r <= req_sync_r[1];
			en_sync_r  <= {en_sync_r[0], ENABLE_PIN};
			oth_sync_r <= {oth_sync_r[0], OTHER_FAULT};
			vin_s1_r   <= VIN_MEAS;
			vin_r      <= vin_s1_r;
			vout_s1_r  <= VOUT_MEAS;
			vout_r     <= vout_s1_r;
		end
	end

	wire req_ev = req_sync_r[1] != req_seen_r;

	// ====================================================================
	// Registers and write checks
	iuv_lin_t     uv_thr_r;
	iuv_lin_t     pg_on_r;
	iuv_lin_t     ton_r;
	logic [7:0]   action_r;
	logic [23:0]  wr_uv_val;
	logic [23:0]  wr_ton_val;
	logic [23:0]  wr_pg_val;
	logic         wr_uv_ok;
	logic         wr_ton_ok;
	logic         wr_pg_ok;
	logic [23:0]  uv_thr_fix;
	logic [23:0]  pg_on_fix;
	logic [23:0]  ton_fix;
	logic         uv_thr_ok;
	logic         pg_on_ok;
	logic         ton_ok;

	iuv_lin11 u_chk_uv (
		.code     (lk_data_r),
		.limit    (`IUV_UV_MAX_FIX),
		.value    (wr_uv_val),
		.in_range (wr_uv_ok)
	);

	iuv_lin11 u_chk_ton (
		.code     (lk_data_r),
		.limit    (`IUV_TON_MAX_FIX),
		.value    (wr_ton_val),
		.in_range (wr_ton_ok)
	);

	iuv_lin11 u_chk_pg (
		.code     (lk_data_r),
		.limit    (`IUV_PG_MAX_FIX),
		.value    (wr_pg_val),
		.in_range (wr_pg_ok)
	);

	// Stored values decoded for the comparators
	iuv_lin11 u_dec_uv (
		.code     (uv_thr_r),
		.limit    (`IUV_UV_MAX_FIX),
		.value    (uv_thr_fix),
		.in_range (uv_thr_ok)
	);

	iuv_lin11 u_dec_pg (
		.code     (pg_on_r),
		.limit    (`IUV_PG_MAX_FIX),
		.value    (pg_on_fix),
		.in_range (pg_on_ok)
	);

	iuv_lin11 u_dec_ton (
		.code     (ton_r),
		.limit    (`IUV_TON_MAX_FIX),
		.value    (ton_fix),
		.in_range (ton_ok)
	);

	// Command decode, one request at a time
	wire hit_uv     = lk_code_r == `IUV_OFS_UV_THR;
	wire hit_pg     = lk_code_r == `IUV_OFS_PG_ON;
	wire hit_ton    = lk_code_r == `IUV_OFS_TURN_ON_DELAY_TIME;
	wire hit_act    = lk_code_r == `IUV_OFS_UV_ACTION;
	wire hit_clr    = lk_code_r == `IUV_OFS_CLEAR;
	wire hit_st     = lk_code_r == `IUV_OFS_STATUS;
	wire do_wr      = req_ev && lk_wr_r;
	wire wr_uv      = do_wr && hit_uv && wr_uv_ok;
	wire wr_pg      = do_wr && hit_pg && wr_pg_ok;
	wire wr_ton     = do_wr && hit_ton && wr_ton_ok;
	wire wr_act     = do_wr && hit_act;
	wire clear_cmd  = do_wr && hit_clr;
	wire wr_refused = (hit_uv && !wr_uv_ok) || (hit_pg && !wr_pg_ok)
	                  || (hit_ton && !wr_ton_ok) || hit_st;
	wire mapped     = hit_uv || hit_pg || hit_ton || hit_act || hit_clr || hit_st;
	wire req_rej    = !mapped || (lk_wr_r ? wr_refused : hit_clr);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			uv_thr_r <= `IUV_RST_UV_THR;
			pg_on_r  <= `IUV_RST_PG_ON;
			ton_r    <= `IUV_RST_TURN_ON_DELAY_TIME;
			action_r <= `IUV_RST_UV_ACTION;
		end else begin
			if (wr_uv)  uv_thr_r <= lk_data_r;
			if (wr_pg)  pg_on_r  <= lk_data_r;
			if (wr_ton) ton_r    <= lk_data_r;
			if (wr_act) action_r <= lk_data_r[7:0];
		end
	end

	// ====================================================================
	// Fault detection and sticky status
	logic         below_r;
	logic         uv_flag_r;
	logic         alert_n_r;
	iuv_state_t   state_r;
	iuv_state_t   state_nxt;

	wire vin_below = {8'h00, vin_r} < uv_thr_fix;
	wire uv_event  = vin_below && !below_r;
	wire uv_flag_nxt = uv_event || (uv_flag_r && !clear_cmd);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			below_r   <= 1'b0;
			uv_flag_r <= 1'b0;
			alert_n_r <= 1'b1;
		end else begin
			below_r   <= vin_below;
			uv_flag_r <= uv_flag_nxt;
			alert_n_r <= !uv_flag_nxt;
		end
	end

	wire [15:0] status_word = {12'h000, state_r == IUV_OFF || state_r == IUV_LATCHED,
	                           uv_flag_r, uv_flag_r, uv_flag_r};

	// Read answer and acknowledge toggle
	wire [15:0] rd_mux = hit_uv  ? uv_thr_r :
	                     hit_pg  ? pg_on_r :
	                     hit_ton ? ton_r :
	                     hit_act ? {8'h00, action_r} :
	                     hit_st  ? status_word : 16'h0000;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sys_ack_tgl_r <= 1'b0;
			sys_rdata_r   <= 16'h0000;
			sys_rej_r     <= 1'b0;
		end else if (req_ev) begin
			sys_ack_tgl_r <= ~sys_ack_tgl_r;
			sys_rdata_r   <= lk_wr_r ? 16'h0000 : rd_mux;
			sys_rej_r     <= req_rej;
		end
	end

	// ====================================================================
	// Millisecond time base, restarted on each state change
	logic [31:0]  tick_cnt_r;
	logic [15:0]  ms_cnt_r;

	wire state_chg = state_nxt != state_r;
	wire ms_tick   = tick_cnt_r == 32'(MS_CYCLES - 1);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tick_cnt_r <= 32'h0;
			ms_cnt_r   <= 16'h0000;
		end else if (state_chg) begin
			tick_cnt_r <= 32'h0;
			ms_cnt_r   <= 16'h0000;
		end else if (ms_tick) begin
			tick_cnt_r <= 32'h0;
			if (ms_cnt_r != 16'hffff) ms_cnt_r <= ms_cnt_r + 16'h0001;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end

	// ====================================================================
	// Sequencer
	wire [1:0]  act_mode  = action_r[`IUV_ACT_MODE_MSB:`IUV_ACT_MODE_LSB];
	wire [2:0]  act_retry = action_r[`IUV_ACT_RETRY_MSB:`IUV_ACT_RETRY_LSB];
	wire [2:0]  act_dly   = action_r[`IUV_ACT_DLY_MSB:`IUV_ACT_DLY_LSB];
	wire        uv_trip   = uv_event && act_mode == `IUV_MODE_RETRY;
	wire        run       = en_sync_r[1] && OP_ON && !oth_sync_r[1];
	wire [15:0] ton_ms    = ton_fix[23:8];
	wire [15:0] retry_ms  = 16'(({13'h0, act_dly} + 16'h0001) * `IUV_RETRY_STEP_MS);
	wire        vin_ok    = vin_r > VIN_UV_WARN;
	wire        no_retry  = act_retry == `IUV_RETRY_NONE;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			IUV_OFF: begin
				if (run) state_nxt = IUV_DELAY;
			end
			IUV_DELAY: begin
				if (uv_trip) state_nxt = no_retry ? IUV_LATCHED : IUV_RETRY_WAIT;
				else if (!run) state_nxt = IUV_OFF;
				else if (ms_cnt_r >= ton_ms) state_nxt = IUV_ON;
			end
			IUV_ON: begin
				if (uv_trip) state_nxt = no_retry ? IUV_LATCHED : IUV_RETRY_WAIT;
				else if (!run) state_nxt = IUV_OFF;
			end
			IUV_RETRY_WAIT: begin
				if (!run) state_nxt = IUV_OFF;
				else if (ms_cnt_r >= retry_ms && vin_ok) state_nxt = IUV_DELAY;
			end
			IUV_LATCHED: state_nxt = IUV_LATCHED;
			default: state_nxt = IUV_OFF;
		endcase
	end

	// ====================================================================
	// Power-good and output flops
	logic pg_r;
	logic out_en_r;

	// set above on level, clear below output UV
	wire pg_set = {8'h00, vout_r} > pg_on_fix;
	wire pg_clr = vout_r < VOUT_UV_FAULT;
	wire pg_nxt = (state_nxt == IUV_ON) && !state_chg &&
	              (pg_r ? !pg_clr : (pg_set && ms_cnt_r >= 16'(`IUV_PG_BLANK_MS)));

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r  <= IUV_OFF;
			pg_r     <= 1'b0;
			out_en_r <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			pg_r     <= pg_nxt;
			out_en_r <= state_nxt == IUV_ON;
		end
	end

	assign OUTPUT_EN        = out_en_r;
	assign POWER_GOOD       = pg_r;
	assign ALERT_LINE_N     = alert_n_r;
	assign STATUS_NOTA      = uv_flag_r;
	assign STATUS_INPUT_SUM = uv_flag_r;
	assign UV_FAULT_FLAG    = uv_flag_r;

endmodule

/* File: iuv_defines.svh */
// ====================================================================
// Constants for the input undervoltage fault and power-good sequencer
// Assumes a 20 MHz system clock; included by bare name, once.
//
// Summary of operation
// - Input dropping below UV fault threshold sets status summary bits, flag, alert.
// - Writes encoding a UV fault threshold outside 0..16 V are refused.
// - A restart waits until input rises above the UV warning threshold.
// - Response bits 7:6 code 10 means disable and retry; others unused.
// - A UV fault pulls the alert low; flag holds until clear-faults.
// - Retry field 000 keeps output off until the device is restarted.
// - Retry field nonzero retries until disabled, operation off or other fault.
// - Retry interval is (delay field + 1) times 35 ms.
// - Power-good sets above its on threshold, clears below output UV fault.
// - Power-good need not assert within 2 ms of enable.
// - Output rise waits turn-on delay 0..125 ms; larger values are refused.
`ifndef IUV_DEFINES_SVH
`define IUV_DEFINES_SVH

// ====================================================================
// Command codes
`define IUV_OFS_UV_THR      8'h59
`define IUV_OFS_PG_ON       8'h5e
`define IUV_OFS_TURN_ON_DELAY_TIME   8'h60
`define IUV_OFS_UV_ACTION   8'hd0
`define IUV_OFS_CLEAR       8'hd1
`define IUV_OFS_STATUS      8'hd2

// ====================================================================
// Field positions and codes
`define IUV_LIN_EXP_MSB     15
`define IUV_LIN_EXP_LSB     11
`define IUV_LIN_MANT_SIGN   10
`define IUV_ACT_MODE_MSB    7
`define IUV_ACT_MODE_LSB    6
`define IUV_ACT_RETRY_MSB   5
`define IUV_ACT_RETRY_LSB   3
`define IUV_ACT_DLY_MSB     2
`define IUV_ACT_DLY_LSB     0
`define IUV_MODE_RETRY      2'h2
`define IUV_RETRY_NONE      3'h0
`define IUV_ST_UV_FAULT     0
`define IUV_ST_INPUT        1
`define IUV_ST_NOTA         2
`define IUV_ST_OFF          3

// ====================================================================
// Reset values
`define IUV_RST_UV_THR      16'hcae6
`define IUV_RST_PG_ON       16'hc800
`define IUV_RST_TURN_ON_DELAY_TIME   16'h0000
`define IUV_RST_UV_ACTION   8'hb8

// ====================================================================
// Range limits, unsigned fixed point with 8 fraction bits
`define IUV_FRAC_BITS       8
`define IUV_UV_MAX_V        16
`define IUV_TON_MAX_MS      125
`define IUV_PG_MAX_V        255
`define IUV_UV_MAX_FIX      24'(`IUV_UV_MAX_V << `IUV_FRAC_BITS)
`define IUV_TON_MAX_FIX     24'(`IUV_TON_MAX_MS << `IUV_FRAC_BITS)
`define IUV_PG_MAX_FIX      24'(`IUV_PG_MAX_V << `IUV_FRAC_BITS)

// ====================================================================
// Timing
`define IUV_CLK_HZ          20000000
`define IUV_MS_CYCLES       (`IUV_CLK_HZ / 1000)
`define IUV_RETRY_STEP_MS   35
`define IUV_PG_BLANK_MS     2

`endif

/* File: iuv_pkg.sv */
// ====================================================================
// Types for the input undervoltage fault and power-good sequencer
// Constants live in iuv_defines.svh.
package iuv_pkg;

	typedef enum logic [2:0] {
		IUV_OFF,
		IUV_DELAY,
		IUV_ON,
		IUV_RETRY_WAIT,
		IUV_LATCHED
	} iuv_state_t;

	typedef logic [15:0] iuv_lin_t;

endpackage

/* File: iuv_lin11.sv */
// ====================================================================
// Linear format decoder and range check
// Assumes the caller supplies an upper limit in 8-fraction-bit fixed point.
`timescale 1ns/1ps
`include "iuv_defines.svh"

module iuv_lin11
	import iuv_pkg::*;
(
	input  wire  iuv_lin_t     code,
	input  wire  logic [23:0]  limit,
	output logic [23:0]        value,
	output logic               in_range
);

	wire [47:0] base;
	wire [4:0]  neg_shift;
	wire [47:0] scaled;

	// ====================================================================
	// exponent scales mantissa
	assign base      = {30'h0, code[9:0], 8'h00};
	assign neg_shift = 5'(~code[`IUV_LIN_EXP_MSB:`IUV_LIN_EXP_LSB]) + 5'h01;
	assign scaled    = code[`IUV_LIN_EXP_MSB] ? (base >> neg_shift)
	                                          : (base << code[14:11]);

	// Negative mantissa means a negative value, never in range
	assign in_range = !code[`IUV_LIN_MANT_SIGN] && (scaled <= {24'h0, limit});
	assign value    = scaled[23:0];

endmodule

/* File: iuv_sequencer_properties.sv */
// Concurrent checks on the undervoltage sequencer outputs
// Assumes it is bound onto iuv_sequencer; all checks run on SYS_CLK
`timescale 1ns/1ps

module iuv_sequencer_chk (
	input wire logic        SYS_CLK,
	input wire logic        RSTN,
	input wire logic        LINK_BUSY,
	input wire logic        OP_ON,
	input wire logic        OTHER_FAULT,
	input wire logic [15:0] VIN_MEAS,
	input wire logic [15:0] VOUT_MEAS,
	input wire logic [15:0] VIN_UV_WARN,
	input wire logic [15:0] VOUT_UV_FAULT,
	input wire logic        OUTPUT_EN,
	input wire logic        POWER_GOOD,
	input wire logic        ALERT_LINE_N,
	input wire logic        STATUS_NOTA,
	input wire logic        STATUS_INPUT_SUM,
	input wire logic        UV_FAULT_FLAG
);
	// ==========
	// Properties; reset masks all, since synchronisers refill after release
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	a_alert_follows_flag: assert property (ALERT_LINE_N == !UV_FAULT_FLAG)
		else $error("alert line disagrees with fault flag");
	a_summary_bits: assert property (STATUS_NOTA == UV_FAULT_FLAG &&
		STATUS_INPUT_SUM == UV_FAULT_FLAG) else $error("summary bits disagree with flag");
	a_flag_cause: assert property ($rose(UV_FAULT_FLAG) |-> VIN_MEAS < VIN_UV_WARN)
		else $error("fault flag rose with input high");
	a_flag_clear_cmd: assert property ($fell(UV_FAULT_FLAG) |-> $past(LINK_BUSY))
		else $error("fault flag cleared without a command");
	a_pg_blank: assert property ($rose(OUTPUT_EN) |-> !POWER_GOOD [*8])
		else $error("power good too early after turn-on");
	a_pg_rise_on: assert property ($rose(POWER_GOOD) |->
		OUTPUT_EN && VOUT_MEAS > VOUT_UV_FAULT) else $error("power good rose wrongly");
	a_pg_drop: assert property (POWER_GOOD && VOUT_MEAS < VOUT_UV_FAULT |->
		##[1:5] !POWER_GOOD) else $error("power good held below fault level");
	a_op_off: assert property (!OP_ON [*3] |-> !OUTPUT_EN)
		else $error("output stayed on after operation off");
	a_fault_off: assert property (OTHER_FAULT [*5] |-> !OUTPUT_EN)
		else $error("output stayed on during other fault");
	a_restart_vin: assert property ($rose(OUTPUT_EN) && UV_FAULT_FLAG |->
		VIN_MEAS > VIN_UV_WARN) else $error("restart below warning level");

	c_uv_event: cover property ($rose(UV_FAULT_FLAG));
	c_pg_up: cover property ($rose(POWER_GOOD));
	c_uv_disable: cover property ($fell(OUTPUT_EN) && UV_FAULT_FLAG);
endmodule

bind iuv_sequencer iuv_sequencer_chk u_chk (
	.SYS_CLK(SYS_CLK), .RSTN(RSTN), .LINK_BUSY(LINK_BUSY), .OP_ON(OP_ON),
	.OTHER_FAULT(OTHER_FAULT), .VIN_MEAS(VIN_MEAS), .VOUT_MEAS(VOUT_MEAS),
	.VIN_UV_WARN(VIN_UV_WARN), .VOUT_UV_FAULT(VOUT_UV_FAULT), .OUTPUT_EN(OUTPUT_EN),
	.POWER_GOOD(POWER_GOOD), .ALERT_LINE_N(ALERT_LINE_N), .STATUS_NOTA(STATUS_NOTA),
	.STATUS_INPUT_SUM(STATUS_INPUT_SUM), .UV_FAULT_FLAG(UV_FAULT_FLAG)
);

/* File: iuv_host.sv */
// Host model issuing one link request at a time
// Assumes a free-running LINK_CLK and a one-cycle done pulse per request
`timescale 1ns/1ps

module iuv_host (
	input  wire logic        LINK_CLK,
	input  wire logic        LINK_BUSY,
	input  wire logic        LINK_DONE,
	input  wire logic        LINK_REJECT,
	input  wire logic [15:0] LINK_RDATA,
	output logic             LINK_WR_STB,
	output logic             LINK_RD_STB,
	output logic [7:0]       LINK_CODE,
	output logic [15:0]      LINK_WDATA
);
	// ==========
	// Requests; released buses show the inverse so stale values never match
	initial begin
		{LINK_WR_STB, LINK_RD_STB, LINK_CODE, LINK_WDATA} = '0;
	end

	task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] dt,
			output logic rej, output logic [15:0] q, output logic tmo);
		int n;
		@(posedge LINK_CLK);
		#2;
		{LINK_WR_STB, LINK_RD_STB, LINK_CODE, LINK_WDATA} = {wr, !wr, c, dt};
		n = 0;
		do begin
			@(posedge LINK_CLK);
			n++;
		end while (LINK_BUSY !== 1'b1 && n < 40);
		#2;
		{LINK_WR_STB, LINK_RD_STB, LINK_CODE, LINK_WDATA} = {2'b00, ~c, ~dt};
		do begin
			@(posedge LINK_CLK);
			n++;
		end while (LINK_DONE !== 1'b1 && n < 40);
		rej = LINK_REJECT;
		q = LINK_RDATA;
		tmo = (n >= 40);
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the undervoltage sequencer
// Assumes the host model drives the link and the bound checker watches outputs
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %s exp %h got %h", nm, e, a); end end

module tb_top;
	logic        SYS_CLK = 1'b0;
	logic        LINK_CLK = 1'b0;
	logic        RSTN, ENABLE_PIN, OP_ON, OTHER_FAULT, LINK_WR_STB, LINK_RD_STB;
	logic        LINK_DONE, LINK_REJECT, LINK_BUSY, OUTPUT_EN, POWER_GOOD;
	logic        ALERT_LINE_N, STATUS_NOTA, STATUS_INPUT_SUM, UV_FAULT_FLAG;
	logic [7:0]  LINK_CODE;
	logic [15:0] VIN_MEAS, VOUT_MEAS, VIN_UV_WARN, VOUT_UV_FAULT, LINK_RDATA, LINK_WDATA;
	int          failures = 0;
	int          checks = 0;
	int          n, d, m;

	// ==========
	// Design and host; one ms is shortened to 10 cycles
	iuv_sequencer #(.MS_CYCLES(10)) u_dut (
		.SYS_CLK(SYS_CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK), .LINK_WR_STB(LINK_WR_STB),
		.LINK_RD_STB(LINK_RD_STB), .LINK_CODE(LINK_CODE), .LINK_WDATA(LINK_WDATA),
		.LINK_RDATA(LINK_RDATA), .LINK_DONE(LINK_DONE), .LINK_REJECT(LINK_REJECT),
		.LINK_BUSY(LINK_BUSY), .ENABLE_PIN(ENABLE_PIN), .OP_ON(OP_ON),
		.OTHER_FAULT(OTHER_FAULT), .VIN_MEAS(VIN_MEAS), .VOUT_MEAS(VOUT_MEAS),
		.VIN_UV_WARN(VIN_UV_WARN), .VOUT_UV_FAULT(VOUT_UV_FAULT), .OUTPUT_EN(OUTPUT_EN),
		.POWER_GOOD(POWER_GOOD), .ALERT_LINE_N(ALERT_LINE_N), .STATUS_NOTA(STATUS_NOTA),
		.STATUS_INPUT_SUM(STATUS_INPUT_SUM), .UV_FAULT_FLAG(UV_FAULT_FLAG));
	iuv_host u_host (
		.LINK_CLK(LINK_CLK), .LINK_BUSY(LINK_BUSY), .LINK_DONE(LINK_DONE),
		.LINK_REJECT(LINK_REJECT), .LINK_RDATA(LINK_RDATA), .LINK_WR_STB(LINK_WR_STB),
		.LINK_RD_STB(LINK_RD_STB), .LINK_CODE(LINK_CODE), .LINK_WDATA(LINK_WDATA));

	// Clocks; link phase offset keeps the two domains unrelated
	always #25 SYS_CLK = ~SYS_CLK;
	initial begin
		#3;
		forever #7.5 LINK_CLK = ~LINK_CLK;
	end

	// ==========
	// Helpers
	task automatic cyc(input int k);
		repeat (k) @(posedge SYS_CLK);
		#2;
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [15:0] lin(input int y, input int e);
		return {e[4:0], y[10:0]};
	endfunction
	task automatic acc(input logic wr, input logic [7:0] c, input logic [15:0] dt,
			output logic rej, output logic [15:0] q);
		logic t;
		u_host.xfer(wr, c, dt, rej, q, t);
		if (t) begin
			failures++;
			end_of_test;
		end
	endtask
	task automatic wchk(input logic [7:0] c, input logic [15:0] dt, input logic erej);
		logic        rej;
		logic [15:0] q;
		acc(1'b1, c, dt, rej, q);
		`CHK("refuse", erej, rej)
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] e, input logic [15:0] k);
		logic        rej;
		logic [15:0] q;
		acc(1'b0, c, 16'h0000, rej, q);
		`CHK("rdata", e, q & k)
	endtask
	// Bounded wait for the output to come on; n counts the cycles
	task automatic wait_en(input int lim);
		n = 0;
		while (OUTPUT_EN !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			failures++;
			end_of_test;
		end
	endtask
	// Input dips to 5 V for 8 cycles, then goes to hi
	task automatic uv_hit(input logic [15:0] hi);
		cyc(1);
		VIN_MEAS = 16'h0500;
		cyc(8);
		`CHK("flag", 1'b1, UV_FAULT_FLAG)
		`CHK("sum", 2'b11, {STATUS_NOTA, STATUS_INPUT_SUM})
		VIN_MEAS = hi;
	endtask
	task automatic do_reset;
		RSTN = 1'b0;
		cyc(12);
		RSTN = 1'b1;
		cyc(4);
	endtask

	// ==========
	// Main sequence
	initial begin
		{RSTN, ENABLE_PIN, OP_ON, OTHER_FAULT} = 4'h0;
		// Input parked at 20 V while thresholds up to 16 V are written
		{VIN_MEAS, VOUT_MEAS} = {16'h1400, 16'h0180};
		{VIN_UV_WARN, VOUT_UV_FAULT} = {16'h1100, 16'h00c0};
		void'($urandom(83));
		do_reset;
		rchk(8'h59, 16'hcae6, 16'hffff);
		rchk(8'h5e, 16'hc800, 16'hffff);
		rchk(8'h60, 16'h0000, 16'hffff);
		rchk(8'hd0, 16'h00b8, 16'h00ff);
		wchk(8'h59, lin(16, 0), 1'b0);
		wchk(8'h59, lin(33, -1), 1'b1);
		wchk(8'h59, lin(-1, 0), 1'b1);
		rchk(8'h59, lin(16, 0), 16'hffff);
		wchk(8'h60, lin(125, 0), 1'b0);
		wchk(8'h60, lin(126, 0), 1'b1);
		rchk(8'h60, lin(125, 0), 16'hffff);
		wchk(8'h33, 16'h1234, 1'b1);
		for (int i = 0; i < 6; i++) begin
			m = $urandom_range(1023, 0);
			wchk(8'h59, lin(m, -6), 1'b0);
			rchk(8'h59, lin(m, -6), 16'hffff);
			wchk(8'h59, lin($urandom_range(1023, 17), 0), 1'b1);
		end
		// Fault at 6 V, 3 ms turn-on delay, power good at 1 V, random retry delay
		wchk(8'h59, lin(6, 0), 1'b0);
		// warning back to 7 V only once the fault level sits below it
		{VIN_UV_WARN, VIN_MEAS} = {16'h0700, 16'h0c00};
		wchk(8'h5e, lin(1, 0), 1'b0);
		wchk(8'h60, lin(3, 0), 1'b0);
		d = $urandom_range(7, 0);
		wchk(8'hd0, {8'h00, 2'b10, 3'b001, d[2:0]}, 1'b0);
		cyc(1);
		{ENABLE_PIN, OP_ON} = 2'b11;
		wait_en(200);
		`CHK("ton", 1'b1, n >= 30 && n <= 38)
		cyc(30);
		`CHK("pg", 1'b1, POWER_GOOD)
		VOUT_MEAS = 16'h0080;
		cyc(6);
		`CHK("pg", 1'b0, POWER_GOOD)
		VOUT_MEAS = 16'h0180;
		// Input parked between fault and warning levels blocks the restart
		uv_hit(16'h0680);
		cyc((d + 1) * 350 + 60);
		`CHK("hold", 1'b0, OUTPUT_EN)
		VIN_MEAS = 16'h0c00;
		wait_en(60);
		uv_hit(16'h0c00);
		wait_en(3000);
		`CHK("gap", 1'b1, n + 8 >= (d + 1) * 350 + 25 && n + 8 <= (d + 1) * 350 + 50)
		rchk(8'hd2, 16'h0007, 16'h0007);
		wchk(8'hd1, 16'h0000, 1'b0);
		cyc(2);
		`CHK("clr", 2'b01, {UV_FAULT_FLAG, ALERT_LINE_N})
		// Commanded off during the retry wait stops further attempts
		uv_hit(16'h0c00);
		ENABLE_PIN = 1'b0;
		cyc((d + 1) * 350 + 60);
		`CHK("off", 1'b0, OUTPUT_EN)
		ENABLE_PIN = 1'b1;
		wait_en(80);
		OTHER_FAULT = 1'b1;
		cyc(6);
		OTHER_FAULT = 1'b0;
		wait_en(80);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) continue;
			wchk(8'hd1, 16'h0000, 1'b0);
			wchk(8'hd0, {8'h00, i[1:0], 6'h08}, 1'b0);
			uv_hit(16'h0c00);
			cyc(400);
			`CHK("mode", 1'b1, OUTPUT_EN)
		end
		// No-retry setting latches off until the device restarts
		wchk(8'hd0, 16'h0080, 1'b0);
		uv_hit(16'h0c00);
		OP_ON = 1'b0;
		cyc(3);
		OP_ON = 1'b1;
		cyc(800);
		`CHK("latch", 1'b0, OUTPUT_EN)
		do_reset;
		wait_en(60);
		end_of_test;
	end
endmodule
